// *** design/i2rp_pkg.sv ***
// Summary of operation
// - Read phase drives the register selected by the stored pointer.
// - Each read byte, acknowledged or not, advances the pointer to the next register in group, wrapping at its end; 0x53 and pointers above 0x6f do not move.
// - No limit on read length; host ends by not acknowledging the last byte.
// - Advanced pointer survives restart and STOP/START; new reads continue from it.
// - Most registers form groups of five for pointer advance.
// - Debounce registers form a group of three; drive and edge registers groups of nine.
// - Repeated reads of the bank-wide output configuration register keep the pointer fixed.
package i2rp_pkg;

	localparam logic [7:0] PTR_RESET   = 8'h00;
	localparam logic [7:0] PTR_FIXED   = 8'h53;
	localparam logic [7:0] PTR_NONE    = 8'h01;
	localparam logic [2:0] BIT_LAST    = 3'h7;
	localparam logic [2:0] BIT_FIRST   = 3'h0;
	localparam logic [6:0] DEV_ADDR_DEF = 7'h20;
	localparam int         GRP_COUNT   = 6;

	// Group ranges, checked in order; the first match wins
	localparam logic [7:0] GRP_LO   [GRP_COUNT] = '{8'h30, 8'h54, 8'h6d, 8'h00, 8'h39, 8'h5d};
	localparam logic [7:0] GRP_HI   [GRP_COUNT] = '{8'h38, 8'h5c, 8'h6f, 8'h2f, 8'h52, 8'h6c};
	localparam logic [7:0] GRP_SIZE [GRP_COUNT] = '{8'h09, 8'h09, 8'h03, 8'h05, 8'h05, 8'h05};

	typedef struct packed {
		logic scl;
		logic sda;
	} i2rp_pins_t;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_ADDR     = 4'h1,
		ST_ADDR_END = 4'h3,
		ST_ACK_A    = 4'h2,
		ST_RX       = 4'h6,
		ST_RX_END   = 4'h7,
		ST_ACK_W    = 4'h5,
		ST_RD       = 4'h4,
		ST_RD_ACK   = 4'hc,
		ST_RD_NEXT  = 4'hd
	} i2rp_state_t;

endpackage

// *** design/i2rp_ptr_step.sv ***
`timescale 1ns/1ps
module i2rp_ptr_step
(
	input  wire logic [7:0] ptr,
	output logic      [7:0] ptr_next
);

	always_comb
	begin
		logic [7:0] off;
		logic [7:0] first;
		logic [7:0] last;
		logic       hit;
		off      = 8'h00;
		first    = 8'h00;
		last     = 8'h00;
		hit      = 1'b0;
		ptr_next = ptr;
		if (ptr == i2rp_pkg::PTR_FIXED)
		begin
			ptr_next = ptr;
		end
		else
		begin
			for (int i = 0; i < i2rp_pkg::GRP_COUNT; i++)
			begin
				if (!hit && ptr >= i2rp_pkg::GRP_LO[i] && ptr <= i2rp_pkg::GRP_HI[i])
				begin
					hit   = 1'b1;
					off   = ptr - i2rp_pkg::GRP_LO[i];
					first = ptr - (off % i2rp_pkg::GRP_SIZE[i]);
					last  = first + i2rp_pkg::GRP_SIZE[i] - i2rp_pkg::PTR_NONE;
					if (last > i2rp_pkg::GRP_HI[i])
					begin
						last = i2rp_pkg::GRP_HI[i];
					end
					ptr_next = (ptr == last) ? first : ptr + i2rp_pkg::PTR_NONE;
				end
			end
		end
	end

endmodule

// *** design/i2rp_read_pointer.sv ***
`timescale 1ns/1ps
module i2rp_read_pointer
#(
	parameter logic [6:0] DEV_ADDR = i2rp_pkg::DEV_ADDR_DEF
)
(
	input  wire logic       clock,
	input  wire logic       arst_n,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n,
	output logic      [7:0] reg_ptr,
	output logic            rd_stb,
	input  wire logic [7:0] rd_data
);

	i2rp_pkg::i2rp_pins_t  meta_r;
	i2rp_pkg::i2rp_pins_t  sync_r;
	i2rp_pkg::i2rp_pins_t  prev_r;

	i2rp_pkg::i2rp_state_t state_r;
	i2rp_pkg::i2rp_state_t state_nxt;
	logic [2:0]            cnt_r;
	logic [2:0]            cnt_nxt;
	logic [7:0]            shift_r;
	logic [7:0]            shift_nxt;
	logic [7:0]            ptr_r;
	logic [7:0]            ptr_nxt;
	logic                  rw_r;
	logic                  rw_nxt;
	logic                  cmd_seen_r;
	logic                  cmd_seen_nxt;
	logic                  oe_n_r;
	logic                  oe_n_nxt;
	logic                  rd_stb_r;
	logic                  rd_stb_nxt;
	logic                  sda_o_r;

	logic [7:0]            ptr_step;
	logic                  scl_rise;
	logic                  scl_fall;
	logic                  start_det;
	logic                  stop_det;

	// Pin synchroniser and edge history
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= '{scl: 1'b1, sda: 1'b1};
			sync_r <= '{scl: 1'b1, sda: 1'b1};
			prev_r <= '{scl: 1'b1, sda: 1'b1};
		end
		else
		begin
			meta_r <= '{scl: scl_i, sda: sda_i};
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign scl_rise  = sync_r.scl & ~prev_r.scl;
	assign scl_fall  = ~sync_r.scl & prev_r.scl;
	assign start_det = sync_r.scl & prev_r.scl & prev_r.sda & ~sync_r.sda;
	assign stop_det  = sync_r.scl & prev_r.scl & ~prev_r.sda & sync_r.sda;

	i2rp_ptr_step u_step
	(
		.ptr      (ptr_r),
		.ptr_next (ptr_step)
	);

	always_comb
	begin
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		shift_nxt    = shift_r;
		ptr_nxt      = ptr_r;
		rw_nxt       = rw_r;
		cmd_seen_nxt = cmd_seen_r;
		oe_n_nxt     = oe_n_r;
		rd_stb_nxt   = 1'b0;
		if (start_det)
		begin
			// Pointer is kept; only the framing restarts
			state_nxt    = i2rp_pkg::ST_ADDR;
			cnt_nxt      = i2rp_pkg::BIT_FIRST;
			cmd_seen_nxt = 1'b0;
			oe_n_nxt     = 1'b1;
		end
		else if (stop_det)
		begin
			state_nxt = i2rp_pkg::ST_IDLE;
			oe_n_nxt  = 1'b1;
		end
		else
		begin
			case (state_r)
				i2rp_pkg::ST_IDLE:
				begin
					oe_n_nxt = 1'b1;
				end
				i2rp_pkg::ST_ADDR, i2rp_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], sync_r.sda};
						cnt_nxt   = cnt_r + 3'h1;
						if (cnt_r == i2rp_pkg::BIT_LAST)
						begin
							state_nxt = (state_r == i2rp_pkg::ST_ADDR) ?
								i2rp_pkg::ST_ADDR_END : i2rp_pkg::ST_RX_END;
						end
					end
				end
				i2rp_pkg::ST_ADDR_END:
				begin
					if (scl_fall)
					begin
						if (shift_r[7:1] == DEV_ADDR)
						begin
							oe_n_nxt  = 1'b0;
							rw_nxt    = shift_r[0];
							state_nxt = i2rp_pkg::ST_ACK_A;
						end
						else
						begin
							state_nxt = i2rp_pkg::ST_IDLE;
						end
					end
				end
				i2rp_pkg::ST_ACK_A:
				begin
					if (scl_fall)
					begin
						cnt_nxt = i2rp_pkg::BIT_FIRST;
						if (rw_r)
						begin
							shift_nxt  = rd_data;
							rd_stb_nxt = 1'b1;
							oe_n_nxt   = rd_data[7];
							state_nxt  = i2rp_pkg::ST_RD;
						end
						else
						begin
							oe_n_nxt  = 1'b1;
							state_nxt = i2rp_pkg::ST_RX;
						end
					end
				end
				i2rp_pkg::ST_RX_END:
				begin
					if (scl_fall)
					begin
						if (!cmd_seen_r)
						begin
							ptr_nxt      = shift_r;
							cmd_seen_nxt = 1'b1;
						end
						oe_n_nxt  = 1'b0;
						state_nxt = i2rp_pkg::ST_ACK_W;
					end
				end
				i2rp_pkg::ST_ACK_W:
				begin
					if (scl_fall)
					begin
						oe_n_nxt  = 1'b1;
						cnt_nxt   = i2rp_pkg::BIT_FIRST;
						state_nxt = i2rp_pkg::ST_RX;
					end
				end
				i2rp_pkg::ST_RD:
				begin
					if (scl_fall)
					begin
						cnt_nxt = cnt_r + 3'h1;
						if (cnt_r == i2rp_pkg::BIT_LAST)
						begin
							oe_n_nxt  = 1'b1;
							state_nxt = i2rp_pkg::ST_RD_ACK;
						end
						else
						begin
							shift_nxt = {shift_r[6:0], 1'b0};
							oe_n_nxt  = shift_r[6];
						end
					end
				end
				i2rp_pkg::ST_RD_ACK:
				begin
					if (scl_rise)
					begin
						// Step on ACK and NACK alike, so a later read resumes past the last byte
						ptr_nxt = ptr_step;
						if (!sync_r.sda)
						begin
							state_nxt = i2rp_pkg::ST_RD_NEXT;
						end
						else
						begin
							state_nxt = i2rp_pkg::ST_IDLE;
						end
					end
				end
				i2rp_pkg::ST_RD_NEXT:
				begin
					if (scl_fall)
					begin
						// No byte count limit on a read
						shift_nxt  = rd_data;
						rd_stb_nxt = 1'b1;
						oe_n_nxt   = rd_data[7];
						cnt_nxt    = i2rp_pkg::BIT_FIRST;
						state_nxt  = i2rp_pkg::ST_RD;
					end
				end
				default:
				begin
					state_nxt = i2rp_pkg::ST_IDLE;
					oe_n_nxt  = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r    <= i2rp_pkg::ST_IDLE;
			cnt_r      <= i2rp_pkg::BIT_FIRST;
			shift_r    <= 8'h00;
			ptr_r      <= i2rp_pkg::PTR_RESET;
			rw_r       <= 1'b0;
			cmd_seen_r <= 1'b0;
			oe_n_r     <= 1'b1;
			rd_stb_r   <= 1'b0;
			sda_o_r    <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			shift_r    <= shift_nxt;
			ptr_r      <= ptr_nxt;
			rw_r       <= rw_nxt;
			cmd_seen_r <= cmd_seen_nxt;
			oe_n_r     <= oe_n_nxt;
			rd_stb_r   <= rd_stb_nxt;
			sda_o_r    <= 1'b0;
		end
	end

	assign sda_o    = sda_o_r;
	assign sda_oe_n = oe_n_r;
	assign reg_ptr  = ptr_r;
	assign rd_stb   = rd_stb_r;

endmodule

// *** sim/i2rp_read_pointer_chk.sv ***
`timescale 1ns/1ps
module i2rp_read_pointer_chk
(
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n,
	input wire logic [7:0] reg_ptr,
	input wire logic       rd_stb
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	a_stb_one_cycle: assert property (rd_stb |=> !rd_stb)
		else $error("strobe too long");
	a_ptr_at_stb: assert property (rd_stb |-> $stable(reg_ptr))
		else $error("pointer moved at strobe");
	a_drive_zero: assert property (!sda_oe_n |-> !sda_o)
		else $error("drive not low");
	a_stop_release: assert property ($rose(sda_i) && scl_i |-> sda_oe_n [*4])
		else $error("drive after stop");
	a_drive_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i && !$past(scl_i, 2))
		else $error("drive change while clock high");
	a_step_on_ack: assert property ($changed(reg_ptr) && scl_i |-> sda_oe_n)
		else $error("step outside ack slot");
	a_fixed_ptr: assert property ($changed(reg_ptr) && scl_i |-> $past(reg_ptr) != 8'h53)
		else $error("fixed pointer moved");
	a_wrap_nine: assert property ($changed(reg_ptr) && scl_i
		&& ($past(reg_ptr) == 8'h38 || $past(reg_ptr) == 8'h5c)
		|-> reg_ptr == $past(reg_ptr) - 8'h08)
		else $error("nine group wrap wrong");
	a_wrap_three: assert property ($changed(reg_ptr) && scl_i
		&& $past(reg_ptr) == 8'h6f |-> reg_ptr == 8'h6d)
		else $error("three group wrap wrong");
	a_step_five: assert property ($changed(reg_ptr) && scl_i
		&& $past(reg_ptr) < 8'h30 |-> reg_ptr == (($past(reg_ptr) == 8'h2f) ? 8'h2d
		: ($past(reg_ptr) % 5 == 4) ? $past(reg_ptr) - 8'h04 : $past(reg_ptr) + 8'h01))
		else $error("five group step wrong");
endmodule

bind i2rp_read_pointer i2rp_read_pointer_chk i2rp_read_pointer_chk_i
(
	.clock    (clock),
	.arst_n   (arst_n),
	.scl_i    (scl_i),
	.sda_i    (sda_i),
	.sda_o    (sda_o),
	.sda_oe_n (sda_oe_n),
	.reg_ptr  (reg_ptr),
	.rd_stb   (rd_stb)
);

// *** sim/i2rp_host.sv ***
`timescale 1ns/1ps
module i2rp_host
(
	input  wire logic            clock,
	input  wire logic            sda_in,
	output i2rp_pkg::i2rp_pins_t pins
);
	initial pins = '{scl: 1'b1, sda: 1'b1};

	task automatic hp();
		repeat (20) @(negedge clock);
	endtask

	task automatic start();
		pins.sda = 1'b1;
		hp();
		pins.scl = 1'b1;
		hp();
		pins.sda = 1'b0;
		hp();
		pins.scl = 1'b0;
	endtask

	task automatic stop();
		pins.sda = 1'b0;
		hp();
		pins.scl = 1'b1;
		hp();
		pins.sda = 1'b1;
		hp();
	endtask

	// Nine bits MSB first; a 1 releases the line
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			pins.sda = d[i];
			hp();
			pins.scl = 1'b1;
			hp();
			q[i] = sda_in;
			pins.scl = 1'b0;
		end
	endtask
endmodule

// *** sim/i2rp_read_pointer_tb.sv ***
`timescale 1ns/1ps
module i2rp_read_pointer_tb;
	localparam logic [7:0] CMDS [8] = '{8'h00, 8'h2d, 8'h53, 8'h36, 8'h5b, 8'h6e, 8'h3b, 8'h5f};
	logic                 clock = 1'b0;
	logic                 arst_n = 1'b0;
	i2rp_pkg::i2rp_pins_t pins;
	logic                 sda_o;
	logic                 sda_oe_n;
	logic                 rd_stb;
	logic           [7:0] reg_ptr;
	logic           [7:0] ep;
	logic           [7:0] exp_q [$];
	logic           [8:0] q;
	int                   err_total = 0;
	int                   tests_run = 0;
	wire                  sda = pins.sda & (sda_oe_n | sda_o);
	wire            [7:0] rd_data = reg_ptr ^ 8'h5a;

	always #2.5 clock = ~clock;

	i2rp_read_pointer i2rp_read_pointer_i (.clock(clock), .arst_n(arst_n), .scl_i(pins.scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .reg_ptr(reg_ptr),
		.rd_stb(rd_stb), .rd_data(rd_data));
	i2rp_host i2rp_host_i (.clock(clock), .sda_in(sda), .pins(pins));

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic tally_and_finish();
		if (exp_q.size() != 0)
			err_total++;
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	function automatic logic [7:0] nx(input logic [7:0] p);
		if (p == 8'h53)
			return p;
		if (p == 8'h38 || p == 8'h5c)
			return p - 8'h08;
		if (p == 8'h6f)
			return 8'h6d;
		if (p == 8'h2f)
			return 8'h2d;
		if (p < 8'h30 && p % 5 == 4)
			return p - 8'h04;
		if (p > 8'h38 && p < 8'h53 && (p - 8'h39) % 5 == 4)
			return p - 8'h04;
		if (p > 8'h5c && p < 8'h6d && (p - 8'h5d) % 5 == 4)
			return p - 8'h04;
		return p + 8'h01;
	endfunction

	task automatic cmd(input logic [7:0] c);
		i2rp_host_i.start();
		i2rp_host_i.xfer({i2rp_pkg::DEV_ADDR_DEF, 2'b01}, q);
		chk({7'h00, q[0]}, 8'h00);
		i2rp_host_i.xfer({c, 1'b1}, q);
		chk({7'h00, q[0]}, 8'h00);
		ep = c;
	endtask

	task automatic rd(input int n);
		i2rp_host_i.start();
		i2rp_host_i.xfer({i2rp_pkg::DEV_ADDR_DEF, 2'b11}, q);
		chk({7'h00, q[0]}, 8'h00);
		for (int i = 0; i < n; i++)
		begin
			exp_q.push_back(ep);
			i2rp_host_i.xfer({8'hff, i == n - 1}, q);
			chk(q[8:1], ep ^ 8'h5a);
			ep = nx(ep);
		end
		i2rp_host_i.stop();
	endtask

	always @(negedge clock)
		if (rd_stb === 1'b1)
			chk(reg_ptr, exp_q.size() != 0 ? exp_q.pop_front() : ~reg_ptr);

	initial
	begin
		repeat (60000) @(posedge clock);
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		void'($urandom(32'hb08a));
		repeat (4) @(negedge clock);
		arst_n = 1'b1;
		repeat (4) @(negedge clock);
		cmd(8'h00);
		i2rp_host_i.xfer({8'h2d, 1'b1}, q);
		chk({7'h00, q[0]}, 8'h00);
		rd(6);
		rd(2);
		i2rp_host_i.start();
		i2rp_host_i.xfer({i2rp_pkg::DEV_ADDR_DEF ^ 7'h01, 2'b11}, q);
		chk({7'h00, q[0]}, 8'h01);
		i2rp_host_i.stop();
		rd(1);
		for (int k = 0; k < 8; k++)
		begin
			cmd(CMDS[k]);
			rd(3 + $urandom % 6);
		end
		tally_and_finish();
	end
endmodule
